// *** hbf_consts.svh ***
`ifndef HBF_CONSTS_SVH
`define HBF_CONSTS_SVH

// ==========================================================
// Structure
`define HBF_PHASES          3
`define HBF_DUTY_W          8

// ==========================================================
// Static mode selection codes
`define HBF_MODE_LIMIT      3'h0
`define HBF_MODE_LATCH      3'h1

// ==========================================================
// Timing, core clock 10 MHz
`define HBF_CLK_PERIOD_NS   100
`define HBF_MIN_LO_NS       100
`define HBF_MIN_LO_CYC      ((`HBF_MIN_LO_NS + `HBF_CLK_PERIOD_NS - 1) \
                             / `HBF_CLK_PERIOD_NS)
`define HBF_RECOVER_WAIT_MS 1000
`define HBF_RECOVER_WAIT_CYC ((`HBF_RECOVER_WAIT_MS * 1000000) \
                              / `HBF_CLK_PERIOD_NS)
`define HBF_RECOVER_CNT_W   24
`define HBF_RST_LO_CYC      4'h4
`define HBF_PWM_PERIOD      8'hC8

`endif

// *** hbf_pkg.sv ***
`include "hbf_consts.svh"
package hbf_pkg;

  typedef logic [`HBF_PHASES-1:0] hbf_phase_t;
  typedef logic [2:0]             hbf_mode_t;

  // Per-phase current limiting state
  typedef enum logic [1:0] {
    LIM_RUN,
    LIM_LO_TRIP,
    LIM_HI_TRIP,
    LIM_PARK
  } hbf_lim_t;

  // Controller recovery sequence
  typedef enum logic [1:0] {
    REC_IDLE,
    REC_WAIT,
    REC_PULSE
  } hbf_rec_t;

endpackage : hbf_pkg

// *** hbf_if.sv ***
`timescale 1ns/1ns
`include "hbf_consts.svh"
interface hbf_if;
  logic [`HBF_PHASES-1:0] pwm;
  logic [`HBF_PHASES-1:0] reset_n;
  logic [2:0]             mode_sel;
  logic                   fault_oe;
  logic                   warn_oe;
  logic                   fault_n;
  logic                   overtemp_warning_n;

  // Open-drain lines with internal pull-up
  assign fault_n            = ~fault_oe;
  assign overtemp_warning_n = ~warn_oe;

  modport dev (
    input  pwm,
    input  reset_n,
    input  mode_sel,
    output fault_oe,
    output warn_oe
  );

  modport ctrl (
    output pwm,
    output reset_n,
    output mode_sel,
    input  fault_n,
    input  overtemp_warning_n
  );
endinterface : hbf_if

// *** hbf_ctrl.sv ***
`timescale 1ns/1ns
`include "hbf_consts.svh"
module hbf_ctrl #(
  parameter int unsigned RECOVER_WAIT = `HBF_RECOVER_WAIT_CYC
) (
  input  wire logic                   I_CORE_CLK,
  input  wire logic                   I_RST,
  input  wire logic [23:0]            I_DUTY,
  input  wire hbf_pkg::hbf_phase_t    I_PHASE_EN,
  input  wire logic                   I_LATCH_SEL,
  input  wire logic                   I_TWO_QUAD,
  input  wire logic                   I_AUTO_RECOVER,
  output logic                        O_FAULT,
  output logic                        O_OVERTEMP_WARN,
  output logic                        O_RECOVERING,
  hbf_if.ctrl                         link
);
  import hbf_pkg::*;

  // ========================================================
  // PWM generation
  localparam logic [7:0] DUTY_MAX =
    8'(`HBF_PWM_PERIOD - `HBF_MIN_LO_CYC);

  logic [7:0]   cnt_r;
  logic [7:0]   cnt_nxt;
  hbf_phase_t   pwm_r;
  hbf_phase_t   pwm_nxt;
  hbf_phase_t   rst_n_r;
  hbf_mode_t    mode_r;
  hbf_rec_t     rec_r;
  hbf_rec_t     rec_nxt;
  logic [`HBF_RECOVER_CNT_W-1:0] wait_r;
  logic [`HBF_RECOVER_CNT_W-1:0] wait_nxt;

  wire period_end = (cnt_r == 8'(`HBF_PWM_PERIOD - 1));
  assign cnt_nxt = period_end ? 8'h00 : 8'(cnt_r + 8'h01);

  genvar g;
  generate
    for (g = 0; g < `HBF_PHASES; g++) begin : g_pwm
      wire [7:0] duty_raw = I_DUTY[g*8 +: 8];
      // Low side always gets its recharge window
      wire [7:0] duty = (duty_raw > DUTY_MAX) ? DUTY_MAX : duty_raw;
      // One input per phase: switching is complementary by build
      assign pwm_nxt[g] = (cnt_r < duty);
    end
  endgenerate

  // ========================================================
  // Fault recovery sequence
  wire fault_seen = ~link.fault_n;
  wire wait_done  =
    (wait_r == `HBF_RECOVER_CNT_W'(RECOVER_WAIT - 1));
  wire pulse_done = (wait_r == `HBF_RECOVER_CNT_W'(`HBF_RST_LO_CYC - 1));
  // Count left nonzero after a pulse: the cleared fault is still in flight
  wire settled    = (wait_r == '0);

  always_comb begin
    rec_nxt  = rec_r;
    wait_nxt = `HBF_RECOVER_CNT_W'(wait_r + 1'b1);
    case (rec_r)
      REC_IDLE: begin
        wait_nxt = '0;
        if (fault_seen && I_AUTO_RECOVER && settled) begin
          rec_nxt = REC_WAIT;
        end
      end
      REC_WAIT: begin
        // Hold off before touching resets after a shutdown
        if (wait_done) begin
          rec_nxt  = REC_PULSE;
          wait_nxt = '0;
        end
      end
      REC_PULSE: begin
        // All three resets low, then the phases set in I_PHASE_EN high together
        if (pulse_done) begin
          rec_nxt = REC_IDLE;
        end
      end
      default: begin
        rec_nxt = REC_IDLE;
      end
    endcase
  end

  always_ff @(posedge I_CORE_CLK) begin
    if (I_RST) begin
      cnt_r   <= 8'h00;
      pwm_r   <= '0;
      rst_n_r <= '0;
      mode_r  <= `HBF_MODE_LIMIT;
      rec_r   <= REC_IDLE;
      wait_r  <= '0;
    end else begin
      cnt_r   <= cnt_nxt;
      pwm_r   <= pwm_nxt;
      // A parked phase wakes on the next PWM toggle
      rst_n_r <= I_PHASE_EN & {`HBF_PHASES{rec_nxt != REC_PULSE}};
      // Held low-side phases would park in limiting mode
      mode_r  <= (I_TWO_QUAD | I_LATCH_SEL) ? `HBF_MODE_LATCH
                                            : `HBF_MODE_LIMIT;
      rec_r   <= rec_nxt;
      wait_r  <= wait_nxt;
    end
  end

  assign link.pwm      = pwm_r;
  assign link.reset_n  = rst_n_r;
  assign link.mode_sel = mode_r;
  assign O_FAULT         = fault_seen;
  assign O_OVERTEMP_WARN = ~link.overtemp_warning_n;
  assign O_RECOVERING    = (rec_r != REC_IDLE);

endmodule : hbf_ctrl

// *** hbf_device.sv ***
// Contract
// - Two overcurrent modes; detectors on both switches
// - Low-side trip: both off until next cycle
// - High-side trip: low side on until next cycle
// - Severe trip in limiting mode latches phase into high impedance
// - Limiting and latch state kept per phase
// - Constant PWM through trip parks phase; toggle wakes
// - Latching mode: no limiting, immediate shutdown
// - Global shutdown clears after all three reset rises
// - Own reset rise clears limiting-mode phase latch
// - Reset low forces phase into high impedance
// - Any supply undervoltage: all phases off, fault
// - Undervoltage recovers by itself when supplies return
// - Power-on reset clears overcurrent state
// - Controller gives low side a minimum pulse
// - Controller picks latching mode for two-quadrant use
// - Controller drives phases with complementary PWM
// - Fault and warning are active-low open drain
// - Controller waits before pulsing resets after shutdown
`timescale 1ns/1ns
`include "hbf_consts.svh"
module hbf_device (
  input  wire logic                   I_CORE_CLK,
  input  wire logic                   I_RST,
  input  wire logic                   I_POR,
  input  wire hbf_pkg::hbf_phase_t    I_OC_HI,
  input  wire hbf_pkg::hbf_phase_t    I_OC_LO,
  input  wire hbf_pkg::hbf_phase_t    I_OC_SEVERE,
  input  wire logic                   I_LOGIC_LOW,
  input  wire hbf_pkg::hbf_phase_t    I_GATE_SUPPLY_LOW,
  input  wire logic                   I_THERMAL_SHUTDOWN,
  input  wire logic                   I_OVERTEMP,
  output hbf_pkg::hbf_phase_t         O_HS_ON,
  output hbf_pkg::hbf_phase_t         O_LS_ON,
  output hbf_pkg::hbf_phase_t         O_PHASE_LATCHED,
  output logic                        O_GLOBAL_LATCHED,
  hbf_if.dev                          link
);
  import hbf_pkg::*;

  // ========================================================
  // Mode and common conditions
  // Unknown codes fall to latching: the safer of the two
  wire limit_mode = (link.mode_sel == `HBF_MODE_LIMIT);
  wire latch_mode = ~limit_mode;

  wire uv_any   = I_LOGIC_LOW | (|I_GATE_SUPPLY_LOW);
  wire oc_clear = I_RST | I_POR;
  wire oc_any   = |(I_OC_HI | I_OC_LO);

  // Latching mode or thermal trip shuts every phase down
  wire glob_set = (latch_mode & oc_any) | I_THERMAL_SHUTDOWN;

  hbf_phase_t pwm_d_r;
  hbf_phase_t rst_d_r;
  hbf_phase_t seen_r;
  hbf_phase_t seen_nxt;
  hbf_phase_t latch_r;
  hbf_phase_t latch_nxt;
  hbf_phase_t hs_nxt;
  hbf_phase_t ls_nxt;
  hbf_phase_t hs_r;
  hbf_phase_t ls_r;
  logic       glob_r;
  logic       glob_nxt;
  logic       fault_r;
  logic       warn_r;

  wire [`HBF_PHASES-1:0] pwm_edge = link.pwm ^ pwm_d_r;
  wire [`HBF_PHASES-1:0] pwm_rise = link.pwm & ~pwm_d_r;
  wire [`HBF_PHASES-1:0] rst_rise = link.reset_n & ~rst_d_r;

  // ========================================================
  // Global latch; every phase reset must rise once
  wire all_seen = &(seen_r | rst_rise);
  assign glob_nxt = glob_set | (glob_r & ~all_seen);
  assign seen_nxt = (glob_r & ~all_seen) ? (seen_r | rst_rise)
                                          : '0;

  // ========================================================
  // Per-phase limiting and latch
  genvar g;
  generate
    for (g = 0; g < `HBF_PHASES; g++) begin : g_ph
      hbf_lim_t lim_r;
      hbf_lim_t lim_nxt;
      logic     fell_r;

      wire trip_ok = limit_mode & ~latch_r[g] & link.reset_n[g];
      wire det_act = (lim_r == LIM_HI_TRIP) ? I_OC_HI[g] : I_OC_LO[g];

      always_comb begin
        lim_nxt = lim_r;
        case (lim_r)
          LIM_RUN: begin
            if (trip_ok && I_OC_HI[g]) begin
              lim_nxt = LIM_HI_TRIP;
            end else if (trip_ok && I_OC_LO[g]) begin
              lim_nxt = LIM_LO_TRIP;
            end
          end
          LIM_LO_TRIP, LIM_HI_TRIP: begin
            if (!trip_ok || pwm_rise[g]) begin
              lim_nxt = LIM_RUN;
            end else if (!det_act && !fell_r && !pwm_edge[g]) begin
              lim_nxt = LIM_PARK;
            end
          end
          LIM_PARK: begin
            if (!trip_ok || pwm_edge[g]) begin
              lim_nxt = LIM_RUN;
            end
          end
          default: begin
            lim_nxt = LIM_RUN;
          end
        endcase
      end

      always_ff @(posedge I_CORE_CLK) begin
        if (oc_clear) begin
          lim_r  <= LIM_RUN;
          fell_r <= 1'b0;
        end else begin
          lim_r  <= lim_nxt;
          // PWM fell during the trip: it is still switching
          fell_r <= (lim_nxt == LIM_LO_TRIP || lim_nxt == LIM_HI_TRIP)
                    & (fell_r | (lim_r != LIM_RUN & pwm_edge[g]));
        end
      end

      // Set wins over a reset rise in the same cycle
      assign latch_nxt[g] = (limit_mode & I_OC_SEVERE[g])
                          | (latch_r[g] & ~(limit_mode & rst_rise[g]));

      wire hiz = ~link.reset_n[g]
               | latch_r[g]
               | glob_r
               | uv_any
               | I_POR
               | (lim_r == LIM_LO_TRIP)
               | (lim_r == LIM_PARK);

      assign hs_nxt[g] = ~hiz & (lim_r == LIM_RUN) & link.pwm[g];
      assign ls_nxt[g] = ~hiz & (((lim_r == LIM_RUN) & ~link.pwm[g])
                              | (lim_r == LIM_HI_TRIP));
    end
  endgenerate

  // ========================================================
  // State and output registers
  always_ff @(posedge I_CORE_CLK) begin
    if (oc_clear) begin
      latch_r <= '0;
      glob_r  <= 1'b0;
      seen_r  <= '0;
    end else begin
      latch_r <= latch_nxt;
      glob_r  <= glob_nxt;
      seen_r  <= seen_nxt;
    end
  end

  always_ff @(posedge I_CORE_CLK) begin
    if (I_RST) begin
      pwm_d_r <= '0;
      rst_d_r <= '0;
      hs_r    <= '0;
      ls_r    <= '0;
      fault_r <= 1'b0;
      warn_r  <= 1'b0;
    end else begin
      pwm_d_r <= link.pwm;
      rst_d_r <= link.reset_n;
      hs_r    <= hs_nxt;
      ls_r    <= ls_nxt;
      // Released only when no source remains
      fault_r <= (|latch_nxt) | glob_nxt | uv_any | I_POR;
      warn_r  <= I_OVERTEMP;
    end
  end

  assign O_HS_ON          = hs_r;
  assign O_LS_ON          = ls_r;
  assign O_PHASE_LATCHED  = latch_r;
  assign O_GLOBAL_LATCHED = glob_r;
  // Open drain: enable high pulls the line low
  assign link.fault_oe = fault_r;
  assign link.warn_oe  = warn_r;

endmodule : hbf_device

// *** hbf_sva.sv ***
`timescale 1ns/1ns
module hbf_sva (
  input wire logic                I_CORE_CLK,
  input wire logic                I_RST,
  input wire logic [2:0]          pwm,
  input wire logic [2:0]          reset_n,
  input wire logic [2:0]          mode_sel,
  input wire logic                fault_oe,
  input wire logic                warn_oe,
  input wire logic                fault_n,
  input wire logic                overtemp_warning_n,
  input wire hbf_pkg::hbf_phase_t I_OC_HI,
  input wire hbf_pkg::hbf_phase_t I_OC_LO,
  input wire hbf_pkg::hbf_phase_t I_OC_SEVERE,
  input wire logic                I_LOGIC_LOW,
  input wire hbf_pkg::hbf_phase_t I_GATE_SUPPLY_LOW,
  input wire logic                I_OVERTEMP,
  input wire logic                I_POR,
  input wire hbf_pkg::hbf_phase_t O_HS_ON,
  input wire hbf_pkg::hbf_phase_t O_LS_ON,
  input wire hbf_pkg::hbf_phase_t O_PHASE_LATCHED,
  input wire logic                O_GLOBAL_LATCHED
);
  import hbf_pkg::*;
  // ==========================================================
  // Helpers
  logic [2:0] rst_q_r;
  logic [2:0] seen_r;
  logic [7:0] hi_cnt_r;
  wire  [2:0] rose_w = reset_n & ~rst_q_r;
  wire  [2:0] all_w  = seen_r | rose_w;
  wire        uv_w   = I_LOGIC_LOW | (|I_GATE_SUPPLY_LOW);
  wire  [2:0] on_w   = O_HS_ON | O_LS_ON;
  always_ff @(posedge I_CORE_CLK) begin
    rst_q_r  <= I_RST ? 3'h0 : reset_n;
    seen_r   <= (I_RST || !O_GLOBAL_LATCHED) ? 3'h0 : all_w;
    hi_cnt_r <= (I_RST || !pwm[0]) ? 8'h00 : hi_cnt_r + 8'h01;
  end
  // ==========================================================
  // Properties
  default clocking cb @(posedge I_CORE_CLK);
  endclocking
  default disable iff (I_RST);
  sequence s_sev_set;
    mode_sel == 3'h0 && I_OC_SEVERE != 3'h0;
  endsequence
  sequence s_sev_held;
    fault_oe && (O_PHASE_LATCHED & $past(I_OC_SEVERE)) == $past(I_OC_SEVERE);
  endsequence
  a_sev_latch: assert property (s_sev_set |=> s_sev_held ##1
    (on_w & $past(I_OC_SEVERE, 2)) == 3'h0) else $error("severe trip");
  a_hi_trip: assert property (mode_sel == 3'h0 && I_OC_HI != 3'h0
    |-> ##2 (O_HS_ON & $past(I_OC_HI, 2)) == 3'h0) else $error("hi trip");
  a_lo_trip: assert property (mode_sel == 3'h0 && I_OC_LO != 3'h0
    |-> ##2 (on_w & $past(I_OC_LO, 2)) == 3'h0) else $error("lo trip");
  a_glob_set: assert property (mode_sel != 3'h0
    && (I_OC_HI | I_OC_LO) != 3'h0 |=> O_GLOBAL_LATCHED && fault_oe)
    else $error("latching mode set");
  a_glob_hiz: assert property (O_GLOBAL_LATCHED |=> on_w == 3'h0)
    else $error("global not off");
  a_all_rise: assert property ($fell(O_GLOBAL_LATCHED)
    && !$past(I_POR) |-> $past(all_w) == 3'h7) else $error("early clear");
  a_rst_hiz: assert property ((on_w & ~$past(reset_n)) == 3'h0)
    else $error("reset low not off");
  a_uv_hiz: assert property (uv_w |=> on_w == 3'h0 && fault_oe)
    else $error("undervoltage");
  a_uv_back: assert property ($fell(uv_w) && !O_GLOBAL_LATCHED
    && O_PHASE_LATCHED == 3'h0 && !I_POR |=> !fault_oe)
    else $error("no recovery");
  a_fault_hold: assert property (O_GLOBAL_LATCHED
    || O_PHASE_LATCHED != 3'h0 |-> fault_oe) else $error("fault dropped");
  a_open_drain: assert property (fault_n == !fault_oe
    && overtemp_warning_n == !warn_oe) else $error("line level");
  a_warn_delay: assert property (warn_oe == $past(I_OVERTEMP))
    else $error("warning timing");
  a_min_low: assert property (hi_cnt_r < 8'hC8)
    else $error("no low pulse");
endmodule : hbf_sva

// *** tb_half_bridge_fault_protection.sv ***
`timescale 1ns/1ns
module tb_half_bridge_fault_protection;
  import hbf_pkg::*;
  logic        clk, rst, lsel, tq, arec, por, llow, tsd, otmp;
  logic        flt, warn, recov, glat;
  logic [23:0] duty;
  hbf_phase_t  en, oh, ol, sev, glow, hs, ls, plat;
  int          n_fail, total_checks, cyc;
  hbf_if hbf_if_inst ();
  hbf_ctrl #(.RECOVER_WAIT(20)) hbf_ctrl_inst (.I_CORE_CLK(clk),
    .I_RST(rst), .I_DUTY(duty), .I_PHASE_EN(en), .I_LATCH_SEL(lsel),
    .I_TWO_QUAD(tq), .I_AUTO_RECOVER(arec), .O_FAULT(flt),
    .O_OVERTEMP_WARN(warn), .O_RECOVERING(recov), .link(hbf_if_inst.ctrl));
  hbf_device hbf_device_inst (.I_CORE_CLK(clk), .I_RST(rst), .I_POR(por),
    .I_OC_HI(oh), .I_OC_LO(ol), .I_OC_SEVERE(sev), .I_LOGIC_LOW(llow),
    .I_GATE_SUPPLY_LOW(glow), .I_THERMAL_SHUTDOWN(tsd), .I_OVERTEMP(otmp),
    .O_HS_ON(hs), .O_LS_ON(ls), .O_PHASE_LATCHED(plat),
    .O_GLOBAL_LATCHED(glat), .link(hbf_if_inst.dev));
  hbf_sva hbf_sva_inst (.I_CORE_CLK(clk), .I_RST(rst),
    .pwm(hbf_if_inst.pwm), .reset_n(hbf_if_inst.reset_n),
    .mode_sel(hbf_if_inst.mode_sel), .fault_oe(hbf_if_inst.fault_oe),
    .warn_oe(hbf_if_inst.warn_oe), .fault_n(hbf_if_inst.fault_n),
    .overtemp_warning_n(hbf_if_inst.overtemp_warning_n), .I_OC_HI(oh),
    .I_OC_LO(ol), .I_OC_SEVERE(sev), .I_LOGIC_LOW(llow),
    .I_GATE_SUPPLY_LOW(glow), .I_OVERTEMP(otmp), .I_POR(por),
    .O_HS_ON(hs), .O_LS_ON(ls), .O_PHASE_LATCHED(plat),
    .O_GLOBAL_LATCHED(glat));
  // ==========================================================
  // Helpers
  task automatic chk(input logic [2:0] got, input logic [2:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic s(input int n);
    repeat (n) @(posedge clk);
    @(negedge clk);
  endtask : s
  task automatic wait_on(input int p);
    for (int i = 0; i < 300 && (hs[p] | ls[p]) !== 1'b1; i++) @(negedge clk);
    chk({2'b0, hs[p] | ls[p]}, 3'h1);
  endtask : wait_on
  task automatic summarize();
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : summarize
  // ==========================================================
  // Scenarios
  task automatic t_reset();
    s(3);
    chk((hs | ls) & 3'h1, 3'h0);
    @(posedge clk); en <= 3'h7; por <= 1'b1;
    s(2); chk({hs | ls}, 3'h0); chk({2'b0, flt}, 3'h1);
    @(posedge clk); por <= 1'b0;
    s(3); chk(hs, 3'h7); chk({2'b0, flt}, 3'h0);
    $display("t_reset done");
  endtask : t_reset
  task automatic t_hi();
    for (int i = 0; i < 300 && hbf_if_inst.pwm[0] !== 1'b0; i++)
      @(negedge clk);
    repeat (10) @(posedge clk);
    oh <= 3'h1; @(posedge clk); oh <= 3'h0;
    s(1); chk({hs[0], ls[0], hs[1]}, 3'h3);
    s(3); chk({1'b0, hs[0], ls[0]}, 3'h0);
    wait_on(0);
    $display("t_hi done");
  endtask : t_hi
  task automatic t_lo();
    @(posedge clk); duty <= 24'hFF_FF00;
    s(3); chk({1'b0, hs[0], ls[0]}, 3'h1);
    @(posedge clk); ol <= 3'h1; @(posedge clk); ol <= 3'h0;
    s(2); chk({1'b0, hs[0], ls[0]}, 3'h0);
    s(3); chk({1'b0, hs[0], ls[0]}, 3'h0);
    @(posedge clk); duty <= 24'hFF_FF64;
    wait_on(0);
    $display("t_lo done");
  endtask : t_lo
  task automatic t_sev();
    @(posedge clk); sev <= 3'h2; @(posedge clk); sev <= 3'h0;
    s(2); chk(plat, 3'h2); chk(hs & 3'h2, 3'h0);
    @(posedge clk); llow <= 1'b1; @(posedge clk); llow <= 1'b0;
    s(3); chk({2'b0, flt}, 3'h1);
    @(posedge clk); en <= 3'h5; @(posedge clk); en <= 3'h7;
    s(4); chk(plat, 3'h0); chk({2'b0, flt}, 3'h0);
    @(posedge clk); sev <= 3'h4; @(posedge clk); sev <= 3'h0;
    @(posedge clk); por <= 1'b1; @(posedge clk); por <= 1'b0;
    s(3); chk(plat, 3'h0);
    $display("t_sev done");
  endtask : t_sev
  task automatic t_uv();
    for (int i = 0; i < 4; i++) begin
      @(posedge clk);
      if (i == 0) llow <= 1'b1;
      else glow[i-1] <= 1'b1;
      s(2); chk(hs | ls, 3'h0); chk({2'b0, flt}, 3'h1);
      @(posedge clk); llow <= 1'b0; glow <= 3'h0;
      s(3); chk(hs | ls, 3'h7); chk({2'b0, flt}, 3'h0);
    end
    @(posedge clk); otmp <= 1'b1;
    s(2); chk({1'b0, warn, flt}, 3'h2);
    @(posedge clk); otmp <= 1'b0;
    s(2); chk({1'b0, warn, flt}, 3'h0);
    $display("t_uv done");
  endtask : t_uv
  task automatic t_latch();
    for (int j = 0; j < 2; j++) begin
      @(posedge clk); lsel <= (j == 0); tq <= (j == 1);
      s(2); chk(hbf_if_inst.mode_sel, 3'h1);
      @(posedge clk); ol <= 3'h4; @(posedge clk); ol <= 3'h0;
      s(2); chk({recov, glat, flt}, 3'h3); chk(hs | ls, 3'h0);
      @(posedge clk); en <= 3'h4; @(posedge clk); en <= 3'h7;
      s(4); chk({recov, glat, flt}, 3'h3);
      @(posedge clk); en <= 3'h3; @(posedge clk); en <= 3'h7;
      s(4); chk({recov, glat, flt}, 3'h0);
    end
    @(posedge clk); tq <= 1'b0;
    $display("t_latch done");
  endtask : t_latch
  task automatic t_auto();
    @(posedge clk); arec <= 1'b1; tsd <= 1'b1; @(posedge clk); tsd <= 1'b0;
    s(10); chk({recov, glat, flt}, 3'h7);
    chk(hbf_if_inst.reset_n, 3'h7);
    for (int i = 0; i < 100 && recov !== 1'b0; i++) @(negedge clk);
    s(3); chk({recov, glat, flt}, 3'h0);
    $display("t_auto done");
  endtask : t_auto
  // ==========================================================
  // Run control
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 6000) begin
      n_fail++;
      summarize();
    end
  end
  initial begin
    {duty, en, lsel, tq, arec, por, oh, ol, sev} = '0;
    {llow, glow, tsd, otmp} = '0;
    rst = 1'b1; n_fail = 0; total_checks = 0; cyc = 0;
    repeat (4) @(posedge clk);
    rst <= 1'b0; duty <= 24'hFF_FFFF; en <= 3'h6;
    t_reset(); t_hi(); t_lo(); t_sev(); t_uv(); t_latch(); t_auto();
    summarize();
  end
endmodule : tb_half_bridge_fault_protection
